// ---- hdl/fru_pkg.sv ----
package fru_pkg;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 5;
  localparam int          INSN_W       = 12;
  // opcode field is instruction bits 11:6, destination bit 5, register select 4:0
  localparam int          OPC_MSB      = 11;
  localparam int          OPC_LSB      = 6;
  localparam int          DEST_BIT     = 5;
  localparam int          REG_MSB      = 4;
  localparam int          REG_LSB      = 0;
  localparam logic [5:0]  OPC_INVERT   = 6'h09;  // 0010 01
  localparam logic [5:0]  OPC_MINUS    = 6'h03;  // 0000 11
  localparam logic [5:0]  OPC_MINUS_SK = 6'h0B;  // 0010 11
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic [7:0]  ONE          = 8'h01;

  typedef enum logic [1:0] {
    FRU_IDLE,
    FRU_EXEC,
    FRU_SKIP
  } fru_state_t;
endpackage : fru_pkg

// ---- hdl/fru_result_reg.sv ----
// result register: latches the computed word on load and holds it until the next load
module fru_result_reg (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // capture side
  input  wire logic                          load,
  input  wire logic [fru_pkg::DATA_W-1:0]    data_in,
  // registered result
  output logic      [fru_pkg::DATA_W-1:0]    data_out
);
  typedef struct packed {
    logic [fru_pkg::DATA_W-1:0] data;
  } fru_rr_st_t;

  fru_rr_st_t st_q;
  fru_rr_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.data = data_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign data_out = st_q.data;
endmodule // fru_result_reg

// ---- hdl/fru_unary_ops.sv ----
module fru_unary_ops (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  // decoder side
  input  wire logic                          insn_valid,
  input  wire logic [fru_pkg::INSN_W-1:0]    insn_word,
  output logic                               insn_ready,
  // register file read port (combinational read)
  output logic      [fru_pkg::ADDR_W-1:0]    rf_raddr,
  input  wire logic [fru_pkg::DATA_W-1:0]    rf_rdata,
  // register file write port
  output logic                               rf_we,
  output logic      [fru_pkg::ADDR_W-1:0]    rf_waddr,
  output logic      [fru_pkg::DATA_W-1:0]    rf_wdata,
  // accumulator and zero flag
  output logic      [fru_pkg::DATA_W-1:0]    acc_value,
  output logic                               zero_flag,
  // skip request to fetch: discard prefetched word
  output logic                               skip_req,
  output logic                               idle_slot
);
  typedef struct packed {
    fru_pkg::fru_state_t        state;
    logic [fru_pkg::DATA_W-1:0] acc;
    logic                       zero;
    logic                       we;
    logic [fru_pkg::ADDR_W-1:0] waddr;
    logic                       skip;
    logic                       done;
  } fru_st_t;

  fru_st_t st_q;
  fru_st_t st_d;
  // kept out of the struct: these two reset on the raw pin, the struct on their output
  logic    rst_m_q;
  logic    rst_s_q;
  logic    rst_n;
  logic    load_res;

  logic [5:0]                 opc;
  logic                       dest;
  logic [fru_pkg::DATA_W-1:0] result;
  logic                       is_inv;
  logic                       is_dec;
  logic                       is_dsk;

  function automatic logic [fru_pkg::DATA_W-1:0] minus_one(input logic [fru_pkg::DATA_W-1:0] v);
    minus_one = v - fru_pkg::ONE;
  endfunction

  // reset release synchroniser: asserts at once, releases two edges later
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_n = rst_s_q;

  assign opc      = insn_word[fru_pkg::OPC_MSB:fru_pkg::OPC_LSB];
  assign dest     = insn_word[fru_pkg::DEST_BIT];
  assign is_inv   = (opc == fru_pkg::OPC_INVERT);
  assign is_dec   = (opc == fru_pkg::OPC_MINUS);
  assign is_dsk   = (opc == fru_pkg::OPC_MINUS_SK);
  assign rf_raddr = insn_word[fru_pkg::REG_MSB:fru_pkg::REG_LSB];

  always_comb begin
    if (is_inv) begin
      result = ~rf_rdata;
    end else begin
      result = minus_one(rf_rdata);
    end
  end

  // busy only during the idle slot that replaces the discarded word
  assign insn_ready = (st_q.state != fru_pkg::FRU_SKIP);
  assign load_res   = insn_valid && insn_ready && (is_inv || is_dec || is_dsk);

  always_comb begin
    st_d       = st_q;
    st_d.we    = 1'b0;
    st_d.skip  = 1'b0;
    st_d.done  = 1'b0;
    case (st_q.state)
      fru_pkg::FRU_IDLE, fru_pkg::FRU_EXEC: begin
        st_d.state = fru_pkg::FRU_IDLE;
        if (load_res) begin
          st_d.state = fru_pkg::FRU_EXEC;
          st_d.done  = 1'b1;
          st_d.waddr = rf_raddr;
          if (dest) begin
            st_d.we = 1'b1;
          end else begin
            st_d.acc = result;
          end
          if (!is_dsk) begin
            st_d.zero = (result == '0);
          end else if (result == '0) begin
            st_d.skip  = 1'b1;
            st_d.state = fru_pkg::FRU_SKIP;
          end
        end
      end
      fru_pkg::FRU_SKIP: begin
        st_d.state = fru_pkg::FRU_IDLE;
      end
      default: begin
        st_d.state = fru_pkg::FRU_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.state <= fru_pkg::FRU_IDLE;
      st_q.acc   <= fru_pkg::ACC_RESET;
      st_q.zero  <= 1'b0;
      st_q.we    <= 1'b0;
      st_q.waddr <= '0;
      st_q.skip  <= 1'b0;
      st_q.done  <= 1'b0;
    end else begin
      st_q.state <= st_d.state;
      st_q.acc   <= st_d.acc;
      st_q.zero  <= st_d.zero;
      st_q.we    <= st_d.we;
      st_q.waddr <= st_d.waddr;
      st_q.skip  <= st_d.skip;
      st_q.done  <= st_d.done;
    end
  end

  fru_result_reg u_result (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .load     (load_res),
    .data_in  (result),
    .data_out (rf_wdata)
  );

  assign rf_we     = st_q.we;
  assign rf_waddr  = st_q.waddr;
  assign acc_value = st_q.acc;
  assign zero_flag = st_q.zero;
  assign skip_req  = st_q.skip;
  assign idle_slot = (st_q.state == fru_pkg::FRU_SKIP);
endmodule // fru_unary_ops

// ---- dv/fru_unary_ops_chk.sv ----
module fru_chk (
  // watched ports
  input wire logic                       sys_clk,
  input wire logic                       arst_n,
  input wire logic                       insn_valid,
  input wire logic [fru_pkg::INSN_W-1:0] insn_word,
  input wire logic                       insn_ready,
  input wire logic [fru_pkg::DATA_W-1:0] rf_rdata,
  input wire logic                       rf_we,
  input wire logic [fru_pkg::ADDR_W-1:0] rf_waddr,
  input wire logic [fru_pkg::DATA_W-1:0] rf_wdata,
  input wire logic [fru_pkg::DATA_W-1:0] acc_value,
  input wire logic                       zero_flag,
  input wire logic                       skip_req,
  input wire logic                       idle_slot
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire tk = insn_valid && insn_ready;
  wire d = insn_word[5];
  wire ik = tk && insn_word[11:6] == fru_pkg::OPC_INVERT;
  wire mk = tk && insn_word[11:6] == fru_pkg::OPC_MINUS;
  wire dk = tk && insn_word[11:6] == fru_pkg::OPC_MINUS_SK;
  wire [7:0] res = rf_we ? rf_wdata : acc_value;
  chk_inv_acc: assert property (ik && !d |=> acc_value == ~$past(rf_rdata) && !rf_we)
    else $error("invert to acc wrong");
  chk_inv_back: assert property (ik && d |=> rf_we && rf_waddr == $past(insn_word[4:0]) && rf_wdata == ~$past(rf_rdata))
    else $error("invert write-back wrong");
  chk_dec_route: assert property (mk |=> res == $past(rf_rdata) - 8'h01 && rf_we == $past(d))
    else $error("minus result wrong");
  chk_dsk_route: assert property (dk |=> res == $past(rf_rdata) - 8'h01 && rf_we == $past(d))
    else $error("skip form result wrong");
  chk_skip_zero: assert property (dk && rf_rdata == 8'h01 |=> skip_req && idle_slot && !insn_ready ##1 !skip_req && insn_ready)
    else $error("skip slot wrong");
  chk_no_skip: assert property (dk && rf_rdata != 8'h01 |=> !skip_req && !idle_slot && insn_ready)
    else $error("spurious skip");
  chk_zero_keep: assert property (dk |=> $stable(zero_flag))
    else $error("skip form touched zero flag");
  chk_zero_upd: assert property (ik || mk |=> zero_flag == (res == 8'h00))
    else $error("zero flag wrong");
  cover property (dk && rf_rdata == 8'h01);
  cover property (ik && d);
  cover property (mk && !d);
endmodule // fru_chk
bind fru_unary_ops fru_chk u_chk (.sys_clk, .arst_n, .insn_valid, .insn_word, .insn_ready, .rf_rdata, .rf_we,
  .rf_waddr, .rf_wdata, .acc_value, .zero_flag, .skip_req, .idle_slot);

// ---- dv/fru_rf_model.sv ----
module fru_rf_model (
  // register file ports
  input wire logic                       sys_clk,
  input wire logic [fru_pkg::ADDR_W-1:0] rf_raddr,
  output logic     [fru_pkg::DATA_W-1:0] rf_rdata,
  input wire logic                       rf_we,
  input wire logic [fru_pkg::ADDR_W-1:0] rf_waddr,
  input wire logic [fru_pkg::DATA_W-1:0] rf_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [32];
  // same-cycle read: the datapath has no wait state
  assign rf_rdata = mem[rf_raddr];
  always @(posedge sys_clk) if (rf_we) mem[rf_waddr] <= rf_wdata;
endmodule // fru_rf_model

// ---- dv/tb_file_reg_unary_ops.sv ----
module tb_file_reg_unary_ops;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, arst_n, insn_valid, insn_ready, rf_we, zero_flag, skip_req, idle_slot, zexp;
  logic [11:0] insn_word;
  logic [4:0] rf_raddr, rf_waddr;
  logic [7:0] rf_rdata, rf_wdata, acc_value;
  int         err_total, samples_checked, cyc;
  fru_unary_ops dut (.sys_clk, .arst_n, .insn_valid, .insn_word, .insn_ready, .rf_raddr, .rf_rdata, .rf_we,
    .rf_waddr, .rf_wdata, .acc_value, .zero_flag, .skip_req, .idle_slot);
  fru_rf_model m (.sys_clk, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata);
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (e !== g) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one instruction with a spare cycle before it, so a skip's idle slot passes unused
  task automatic run(logic [5:0] op, logic d, logic [4:0] r, logic [7:0] v, logic [7:0] e, logic sk);
    @(posedge sys_clk) #1;
    m.mem[r] = v;
    insn_word = {op, d, r};
    insn_valid = 1;
    @(posedge sys_clk) #1;
    insn_valid = 0;
    if (op != fru_pkg::OPC_MINUS_SK) zexp = (e == 8'h00);
    chk("result", e, d ? rf_wdata : acc_value);
    chk("write", 8'(d), 8'(rf_we));
    if (d) chk("waddr", 8'(r), 8'(rf_waddr));
    chk("skip", 8'(sk), 8'(skip_req));
    chk("idle", 8'(sk), 8'(idle_slot));
    chk("ready", 8'(!sk), 8'(insn_ready));
    chk("zero", 8'(zexp), 8'(zero_flag));
  endtask
  task automatic t_invert();
    run(fru_pkg::OPC_INVERT, 1'h0, 5'h03, 8'h13, 8'hEC, 1'h0);
    run(fru_pkg::OPC_INVERT, 1'h1, 5'h1F, 8'hFF, 8'h00, 1'h0);
    $display("test invert end");
  endtask
  task automatic t_minus();
    run(fru_pkg::OPC_MINUS, 1'h1, 5'h00, 8'h01, 8'h00, 1'h0);
    run(fru_pkg::OPC_MINUS, 1'h0, 5'h07, 8'h00, 8'hFF, 1'h0);
    $display("test minus end");
  endtask
  task automatic t_skip();
    run(fru_pkg::OPC_MINUS_SK, 1'h1, 5'h1F, 8'h02, 8'h01, 1'h0);
    run(fru_pkg::OPC_MINUS_SK, 1'h0, 5'h09, 8'h01, 8'h00, 1'h1);
    $display("test skip end");
  endtask
  // a word offered in the idle slot after a skip must be refused
  task automatic t_refuse();
    run(fru_pkg::OPC_MINUS_SK, 1'h0, 5'h0A, 8'h01, 8'h00, 1'h1);
    m.mem[5'h0B] = 8'h55;
    insn_word = {fru_pkg::OPC_INVERT, 1'b0, 5'h0B};
    insn_valid = 1;
    @(posedge sys_clk) #1;
    insn_valid = 0;
    chk("refused acc", 8'h00, acc_value);
    chk("ready after slot", 8'h01, 8'(insn_ready));
    $display("test refuse end");
  endtask
  initial begin
    arst_n = 0;
    insn_valid = 0;
    insn_word = 12'h000;
    zexp = 0;
    repeat (6) @(posedge sys_clk);
    #1 arst_n = 1;
    repeat (2) @(posedge sys_clk);
    t_invert();
    t_minus();
    t_skip();
    t_refuse();
    summarize();
  end
endmodule // tb_file_reg_unary_ops
